// File: core/snc_pkg.sv
package snc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SNC_OFF_NVM_MODE   = 8'h6A;
  localparam logic [7:0] SNC_OFF_IF_SET     = 8'h6B;
  localparam logic [7:0] SNC_OFF_SELFTEST   = 8'h6D;
  localparam logic [7:0] SNC_OFF_PERSIST    = 8'h70;
  localparam logic [7:0] SNC_OFF_X_OFFSET   = 8'h71;
  localparam logic [7:0] SNC_OFF_CMD        = 8'h7E;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned SNC_BIT_PROG_EN     = 1;
  localparam int unsigned SNC_BIT_THREE_WIRE  = 0;
  localparam int unsigned SNC_BIT_AUX_MODE    = 4;
  localparam int unsigned SNC_BIT_ST_EN       = 0;
  localparam int unsigned SNC_BIT_ST_SIGN     = 2;
  localparam int unsigned SNC_BIT_ST_AMP      = 3;
  localparam int unsigned SNC_BIT_SPI_EN      = 0;
  localparam int unsigned SNC_BIT_WDT_SEL     = 1;
  localparam int unsigned SNC_BIT_WDT_EN      = 2;
  localparam int unsigned SNC_BIT_OFF_EN      = 3;
  localparam int unsigned SNC_PERSIST_BITS    = 4;

  // ----------------------------------------------------------------
  // reset values and command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SNC_RST_REG        = 8'h00;
  localparam logic [7:0] SNC_READ_ZERO      = 8'h00;
  localparam logic [7:0] SNC_CMD_NVM_PROG   = 8'hA0;

  // ----------------------------------------------------------------
  // watchdog timing
  // ----------------------------------------------------------------
  localparam longint SNC_CLK_MHZ         = 20;
  localparam longint SNC_WDT_SHORT_NS    = 1_250_000;
  localparam longint SNC_WDT_LONG_NS     = 40_000_000;
  localparam int unsigned SNC_WDT_W      = 20;
  localparam logic [SNC_WDT_W-1:0] SNC_WDT_SHORT_CYC =
    SNC_WDT_W'((SNC_WDT_SHORT_NS * SNC_CLK_MHZ) / 1000);
  localparam logic [SNC_WDT_W-1:0] SNC_WDT_LONG_CYC =
    SNC_WDT_W'((SNC_WDT_LONG_NS * SNC_CLK_MHZ) / 1000);
  localparam logic [SNC_WDT_W-1:0] SNC_WDT_ONE = 20'h00001;
  localparam logic [SNC_WDT_W-1:0] SNC_WDT_ZERO = 20'h00000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } snc_req_s;

  typedef struct packed {
    logic [SNC_PERSIST_BITS-1:0] persist;
    logic [7:0]                  off_x;
  } snc_nvm_img_s;

  typedef struct packed {
    logic en;
    logic positive;
    logic high;
  } snc_st_s;

  typedef struct packed {
    logic             valid;
    logic [1:0][15:0] data;
  } snc_smp_s;

  typedef enum logic [1:0] {
    SNC_NVM_IDLE = 2'b01,
    SNC_NVM_PROG = 2'b10
  } snc_nvm_st_e;

endpackage

// File: core/snc_wdt.sv
`timescale 1ns/100ps
module snc_wdt
  import snc_pkg::*;
#(
  parameter logic [SNC_WDT_W-1:0] SHORT_CYC = SNC_WDT_SHORT_CYC,
  parameter logic [SNC_WDT_W-1:0] LONG_CYC  = SNC_WDT_LONG_CYC
)(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // pin and control
  input  wire logic serial_data_input_pin,
  input  wire logic i2c_mode,
  input  wire logic wdt_en,
  input  wire logic wdt_long,
  // result
  output logic      timeout_ff
);

  logic                 pin_meta_ff;
  logic                 pin_sync_ff;
  logic [SNC_WDT_W-1:0] cnt_ff;
  logic [SNC_WDT_W-1:0] limit;
  logic                 armed;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end
    else
    begin
      pin_meta_ff <= serial_data_input_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign limit = wdt_long ? LONG_CYC : SHORT_CYC;
  assign armed = wdt_en & i2c_mode & ~pin_sync_ff;

  // a line stuck low fires once; the count holds until the line is released
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff     <= SNC_WDT_ZERO;
      timeout_ff <= 1'b0;
    end
    else
    begin
      timeout_ff <= armed && (cnt_ff == limit - SNC_WDT_ONE);
      if (!armed)
        cnt_ff <= SNC_WDT_ZERO;
      else if (cnt_ff != limit)
        cnt_ff <= cnt_ff + SNC_WDT_ONE;
    end
  end

endmodule

// File: core/snc_offset.sv
`timescale 1ns/100ps
module snc_offset
  import snc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // control
  input  wire logic       add_en,
  input  wire logic [7:0] off_x,
  // samples
  input  wire snc_smp_s   acc_in,
  output snc_smp_s        acc_out_ff
);

  logic [15:0] off_ext;
  logic        valid_ff;
  logic [15:0] data_ff [2];

  assign off_ext = add_en ? {{8{off_x[7]}}, off_x} : 16'h0000;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      valid_ff <= 1'b0;
    else
      valid_ff <= acc_in.valid;
  end

  // one driver for the whole output word keeps the struct single-sourced
  assign acc_out_ff = {valid_ff, data_ff[1], data_ff[0]};

  // index 0 filtered, index 1 unfiltered; the sum wraps, no saturation
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          data_ff[ch] <= 16'h0000;
        else if (acc_in.valid)
          data_ff[ch] <= acc_in.data[ch] + off_ext;
      end
    end
  endgenerate

endmodule

// File: core/snc_regs.sv
`timescale 1ns/100ps
module snc_regs
  import snc_pkg::*;
#(
  parameter logic [SNC_WDT_W-1:0] WDT_SHORT_CYC = SNC_WDT_SHORT_CYC,
  parameter logic [SNC_WDT_W-1:0] WDT_LONG_CYC  = SNC_WDT_LONG_CYC
)(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // register port from the serial front end
  input  wire snc_pkg::snc_req_s      reg_req,
  output logic [7:0]                  rdata_ff,
  output logic                        rvalid_ff,
  // nonvolatile memory controller
  input  wire logic                   nvm_load_valid,
  input  wire snc_pkg::snc_nvm_img_s  nvm_load_img,
  input  wire logic                   nvm_done,
  output logic                        nvm_prog_allow_ff,
  output logic                        nvm_prog_start_ff,
  output snc_pkg::snc_nvm_img_s       nvm_prog_img_ff,
  output logic                        nvm_busy_ff,
  // primary and auxiliary interface control
  input  wire logic                   autoconfig_mode,
  input  wire logic                   i2c_mode,
  input  wire logic                   serial_data_input_pin,
  output logic                        three_wire_select_ff,
  output logic                        aux_mag_en_ff,
  output logic                        i2c_disable_ff,
  output logic                        i2c_wdt_timeout_ff,
  // self-test excitation
  output snc_pkg::snc_st_s            selftest_ff,
  // acceleration samples
  input  wire snc_pkg::snc_smp_s      acc_in,
  output snc_pkg::snc_smp_s           acc_out_ff
);

  import snc_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // only the backed bits are kept as a word; other fields sit in named flops
  logic [SNC_PERSIST_BITS-1:0] persist_ff;
  logic [7:0]                  off_x_ff;
  snc_nvm_st_e                 nvm_st_ff;
  snc_nvm_st_e                 nxt_nvm_st;
  logic [7:0]                  nxt_rdata;
  logic                        wr_nvm_mode;
  logic                        wr_if_set;
  logic                        wr_selftest;
  logic                        wr_persist;
  logic                        wr_x_offset;
  logic                        cmd_prog;
  logic                        prog_launch;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // unmapped offsets fall through: writes are dropped, reads give zero
  // a read and a write in one cycle return the value held before the write
  assign wr_nvm_mode = reg_req.wr & reg_hit(reg_req.addr, SNC_OFF_NVM_MODE);
  assign wr_if_set   = reg_req.wr & reg_hit(reg_req.addr, SNC_OFF_IF_SET);
  assign wr_selftest = reg_req.wr & reg_hit(reg_req.addr, SNC_OFF_SELFTEST);
  assign wr_persist  = reg_req.wr & reg_hit(reg_req.addr, SNC_OFF_PERSIST);
  assign wr_x_offset = reg_req.wr & reg_hit(reg_req.addr, SNC_OFF_X_OFFSET);
  // only the program code acts here; the command location itself reads as zero
  assign cmd_prog    = reg_req.wr & reg_hit(reg_req.addr, SNC_OFF_CMD)
                     & (reg_req.wdata == SNC_CMD_NVM_PROG);

  // ----------------------------------------------------------------
  // nonvolatile mode control
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      nvm_prog_allow_ff <= SNC_RST_REG[SNC_BIT_PROG_EN];
    else if (wr_nvm_mode)
      nvm_prog_allow_ff <= reg_req.wdata[SNC_BIT_PROG_EN];
  end

  // ----------------------------------------------------------------
  // serial interface settings
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      three_wire_select_ff <= SNC_RST_REG[SNC_BIT_THREE_WIRE];
      aux_mag_en_ff        <= SNC_RST_REG[SNC_BIT_AUX_MODE];
    end
    else if (wr_if_set)
    begin
      three_wire_select_ff <= reg_req.wdata[SNC_BIT_THREE_WIRE];
      aux_mag_en_ff        <= reg_req.wdata[SNC_BIT_AUX_MODE];
    end
  end

  // ----------------------------------------------------------------
  // self-test control
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      selftest_ff.en       <= SNC_RST_REG[SNC_BIT_ST_EN];
      selftest_ff.positive <= SNC_RST_REG[SNC_BIT_ST_SIGN];
      selftest_ff.high     <= SNC_RST_REG[SNC_BIT_ST_AMP];
    end
    else if (wr_selftest)
    begin
      selftest_ff.en       <= reg_req.wdata[SNC_BIT_ST_EN];
      selftest_ff.positive <= reg_req.wdata[SNC_BIT_ST_SIGN];
      selftest_ff.high     <= reg_req.wdata[SNC_BIT_ST_AMP];
    end
  end

  // ----------------------------------------------------------------
  // persistent interface options and X offset
  // ----------------------------------------------------------------
  // the boot image load beats a host write landing in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      persist_ff <= SNC_RST_REG[SNC_PERSIST_BITS-1:0];
    else if (nvm_load_valid)
      persist_ff <= nvm_load_img.persist;
    else if (wr_persist)
      persist_ff <= reg_req.wdata[SNC_PERSIST_BITS-1:0];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      off_x_ff <= SNC_RST_REG;
    else if (nvm_load_valid)
      off_x_ff <= nvm_load_img.off_x;
    else if (wr_x_offset)
      off_x_ff <= reg_req.wdata;
  end

  // registered so the front end sees a clean level
  // the option only matters while the front end is still detecting its mode
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      i2c_disable_ff <= 1'b0;
    else
      i2c_disable_ff <= autoconfig_mode & persist_ff[SNC_BIT_SPI_EN];
  end

  // ----------------------------------------------------------------
  // nvm program sequence
  // ----------------------------------------------------------------
  // a command while locked or busy is dropped silently; software polls busy
  always_comb
  begin
    nxt_nvm_st = nvm_st_ff;
    case (nvm_st_ff)
      SNC_NVM_IDLE:
      begin
        if (cmd_prog && nvm_prog_allow_ff)
          nxt_nvm_st = SNC_NVM_PROG;
      end
      SNC_NVM_PROG:
      begin
        if (nvm_done)
          nxt_nvm_st = SNC_NVM_IDLE;
      end
      default:
        nxt_nvm_st = SNC_NVM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      nvm_st_ff <= SNC_NVM_IDLE;
    else
      nvm_st_ff <= nxt_nvm_st;
  end

  // one decode serves both the start pulse and the image capture, so they agree
  assign prog_launch = (nvm_st_ff == SNC_NVM_IDLE) && (nxt_nvm_st == SNC_NVM_PROG);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      nvm_prog_start_ff <= 1'b0;
      nvm_busy_ff       <= 1'b0;
    end
    else
    begin
      nvm_prog_start_ff <= prog_launch;
      nvm_busy_ff       <= (nxt_nvm_st == SNC_NVM_PROG);
    end
  end

  // the image is frozen at the command so later writes cannot tear it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      nvm_prog_img_ff.persist <= SNC_RST_REG[SNC_PERSIST_BITS-1:0];
      nvm_prog_img_ff.off_x   <= SNC_RST_REG;
    end
    else if (prog_launch)
    begin
      nvm_prog_img_ff.persist <= persist_ff;
      nvm_prog_img_ff.off_x   <= off_x_ff;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = SNC_READ_ZERO;
    // reserved positions keep the zero default, so they always read back as zero
    case (reg_req.addr)
      SNC_OFF_NVM_MODE:
        nxt_rdata[SNC_BIT_PROG_EN] = nvm_prog_allow_ff;
      SNC_OFF_IF_SET:
      begin
        nxt_rdata[SNC_BIT_THREE_WIRE] = three_wire_select_ff;
        nxt_rdata[SNC_BIT_AUX_MODE]   = aux_mag_en_ff;
      end
      SNC_OFF_SELFTEST:
      begin
        nxt_rdata[SNC_BIT_ST_EN]   = selftest_ff.en;
        nxt_rdata[SNC_BIT_ST_SIGN] = selftest_ff.positive;
        nxt_rdata[SNC_BIT_ST_AMP]  = selftest_ff.high;
      end
      SNC_OFF_PERSIST:
        nxt_rdata[SNC_PERSIST_BITS-1:0] = persist_ff;
      SNC_OFF_X_OFFSET:
        nxt_rdata = off_x_ff;
      default:
        nxt_rdata = SNC_READ_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff  <= SNC_READ_ZERO;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_req.rd;
      if (reg_req.rd)
        rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // watchdog on the data pin
  // ----------------------------------------------------------------
  // the raw pin is synchronised inside the watchdog before any logic reads it
  snc_wdt #(
    .SHORT_CYC (WDT_SHORT_CYC),
    .LONG_CYC  (WDT_LONG_CYC)
  ) u_wdt (
    .ref_clk               (ref_clk),
    .rst                   (rst),
    .serial_data_input_pin (serial_data_input_pin),
    .i2c_mode              (i2c_mode),
    .wdt_en                (persist_ff[SNC_BIT_WDT_EN]),
    .wdt_long              (persist_ff[SNC_BIT_WDT_SEL]),
    .timeout_ff            (i2c_wdt_timeout_ff)
  );

  // ----------------------------------------------------------------
  // offset compensation
  // ----------------------------------------------------------------
  // the enable is a backed bit, so a restored image applies the offset at once
  snc_offset u_offset (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .add_en     (persist_ff[SNC_BIT_OFF_EN]),
    .off_x      (off_x_ff),
    .acc_in     (acc_in),
    .acc_out_ff (acc_out_ff)
  );

endmodule

// File: test/snc_regs_checker.sv
`timescale 1ns/100ps
module snc_regs_checker
  import snc_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // register port
  input wire snc_pkg::snc_req_s reg_req,
  input wire logic              rvalid_ff,
  // nonvolatile memory controller
  input wire logic              nvm_done,
  input wire logic              nvm_prog_allow_ff,
  input wire logic              nvm_prog_start_ff,
  input wire logic              nvm_busy_ff,
  // interface control
  input wire logic              autoconfig_mode,
  input wire logic              three_wire_select_ff,
  input wire logic              aux_mag_en_ff,
  input wire logic              i2c_disable_ff,
  input wire snc_pkg::snc_st_s  selftest_ff,
  // samples
  input wire snc_pkg::snc_smp_s acc_in,
  input wire snc_pkg::snc_smp_s acc_out_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence wr_at(logic [7:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence
  sequence prog_cmd;
    wr_at(SNC_OFF_CMD) ##0 reg_req.wdata == SNC_CMD_NVM_PROG && nvm_prog_allow_ff && !nvm_busy_ff;
  endsequence
  sequence prog_pulse;
    nvm_prog_start_ff && nvm_busy_ff ##1 !nvm_prog_start_ff;
  endsequence

  rd_answer_a: assert property (reg_req.rd |=> rvalid_ff)
    else $error("read not answered");
  rd_quiet_a: assert property (!reg_req.rd |=> !rvalid_ff)
    else $error("read answer without read");
  prog_allow_a: assert property (wr_at(SNC_OFF_NVM_MODE) |=>
    nvm_prog_allow_ff == $past(reg_req.wdata[1])) else $error("prog enable wrong");
  wire_mode_a: assert property (wr_at(SNC_OFF_IF_SET) |=>
    three_wire_select_ff == $past(reg_req.wdata[0])) else $error("wire mode wrong");
  aux_mode_a: assert property (wr_at(SNC_OFF_IF_SET) |=>
    aux_mag_en_ff == $past(reg_req.wdata[4])) else $error("aux mode wrong");
  selftest_bits_a: assert property (wr_at(SNC_OFF_SELFTEST) |=> selftest_ff ==
    {$past(reg_req.wdata[0]), $past(reg_req.wdata[2]), $past(reg_req.wdata[3])})
    else $error("self-test bits wrong");
  i2c_keep_a: assert property (!autoconfig_mode |=> !i2c_disable_ff)
    else $error("i2c disabled outside autoconfig");
  prog_start_a: assert property (prog_cmd |=> prog_pulse)
    else $error("program command not started");
  start_cause_a: assert property (!(reg_req.wr && reg_req.addr == SNC_OFF_CMD)
    |=> !nvm_prog_start_ff) else $error("program start without command");
  busy_hold_a: assert property (nvm_busy_ff && !nvm_done |=> nvm_busy_ff)
    else $error("busy dropped early");
  sample_valid_a: assert property (acc_in.valid |=> acc_out_ff.valid)
    else $error("sample not passed on");
endmodule

bind snc_regs snc_regs_checker snc_regs_checker_inst (
  .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .rvalid_ff(rvalid_ff),
  .nvm_done(nvm_done), .nvm_prog_allow_ff(nvm_prog_allow_ff),
  .nvm_prog_start_ff(nvm_prog_start_ff), .nvm_busy_ff(nvm_busy_ff),
  .autoconfig_mode(autoconfig_mode), .three_wire_select_ff(three_wire_select_ff),
  .aux_mag_en_ff(aux_mag_en_ff), .i2c_disable_ff(i2c_disable_ff),
  .selftest_ff(selftest_ff), .acc_in(acc_in), .acc_out_ff(acc_out_ff));

// File: test/snc_nvm_model.sv
`timescale 1ns/100ps
module snc_nvm_model
  import snc_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // program request
  input  wire logic                  prog_start,
  input  wire snc_pkg::snc_nvm_img_s prog_img,
  input  wire logic [7:0]            dly,
  // answer
  output logic                       done,
  output snc_pkg::snc_nvm_img_s      stored = '0,
  output int                         progs = 0
);
  logic [7:0] cnt;
  // stored image survives reset, as nonvolatile cells do
  always @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      cnt <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      done <= (cnt == 8'h01);
      if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
      if (prog_start)
      begin
        stored <= prog_img;
        progs <= progs + 1;
        cnt <= dly;
      end
    end
endmodule

// File: test/snc_regs_tb.sv
`timescale 1ns/100ps
module snc_regs_tb;
  import snc_pkg::*;
  localparam logic [7:0] ADR [7] = '{SNC_OFF_NVM_MODE, SNC_OFF_IF_SET, SNC_OFF_SELFTEST,
    SNC_OFF_PERSIST, SNC_OFF_X_OFFSET, SNC_OFF_CMD, 8'h6C};
  localparam logic [7:0] MSK [7] = '{8'h02, 8'h11, 8'h0D, 8'h0F, 8'hFF, 8'h00, 8'h00};
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  snc_req_s     req = '0;
  snc_smp_s     ai = '0;
  snc_smp_s     ao;
  snc_nvm_img_s pimg;
  snc_nvm_img_s nv_img;
  snc_st_s      st;
  logic         nld = 1'b0;
  logic         ac = 1'b0;
  logic         im = 1'b0;
  logic         pin = 1'b1;
  logic [7:0]   dly = 8'h01;
  logic         done, allow, start, busy, tw, aux, i2d, to, rv;
  logic [7:0]   rd;
  int           progs;
  int           num_errors = 0;
  int           samples_checked = 0;
  logic [7:0]   expq [$];

  always #25 ref_clk = ~ref_clk;

  snc_regs #(.WDT_SHORT_CYC(20'h00014), .WDT_LONG_CYC(20'h0003C)) snc_regs_inst (
    .ref_clk(ref_clk), .rst(rst), .reg_req(req), .rdata_ff(rd), .rvalid_ff(rv),
    .nvm_load_valid(nld), .nvm_load_img(nv_img), .nvm_done(done),
    .nvm_prog_allow_ff(allow), .nvm_prog_start_ff(start), .nvm_prog_img_ff(pimg),
    .nvm_busy_ff(busy), .autoconfig_mode(ac), .i2c_mode(im), .serial_data_input_pin(pin),
    .three_wire_select_ff(tw), .aux_mag_en_ff(aux), .i2c_disable_ff(i2d),
    .i2c_wdt_timeout_ff(to), .selftest_ff(st), .acc_in(ai), .acc_out_ff(ao));
  snc_nvm_model snc_nvm_model_inst (.ref_clk(ref_clk), .rst(rst), .prog_start(start),
    .prog_img(pimg), .dly(dly), .done(done), .stored(nv_img), .progs(progs));

  // ----
  // checking and closing
  // ----
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
    if (rv === 1'b1)
      chk(rd, expq.pop_front());

  // ----
  // register access: one request per two cycles
  // ----
  task automatic acc(logic w, logic r, logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    req <= '{w, r, a, d};
    @(posedge ref_clk);
    req <= '0;
  endtask
  task automatic rdx(logic [7:0] a, logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, 1'b1, a, 8'h00);
  endtask

  // run needs well under 2000 cycles; 40000 leaves ample margin
  initial
  begin
    #2_000_000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    logic [7:0] d [7];
    int         n;
    int         p0;
    void'($urandom(32'h6f8ca01a));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rdx(ADR[i], SNC_RST_REG);
    // spi enable, offset enable and autoconfig are stepped so every level is seen
    for (int r = 0; r < 4; r++)
    begin
      for (int i = 0; i < 7; i++)
      begin
        d[i] = $urandom();
        if (d[i] == SNC_CMD_NVM_PROG)
          d[i] = 8'h00;
        if (i == 3)
          d[i] = {d[i][7:4], r[0], d[i][2:1], r[1]};
        acc(1'b1, 1'b0, ADR[i], d[i]);
      end
      ac <= r[0] ^ r[1];
      ai <= '{1'b1, 32'($urandom())};
      @(posedge ref_clk);
      ai.valid <= 1'b0;
      #1;
      chk(allow, d[0][1]);
      chk(tw, d[1][0]);
      chk(aux, d[1][4]);
      chk(st, {d[2][0], d[2][2], d[2][3]});
      chk(i2d, ac & d[3][0]);
      for (int c = 0; c < 2; c++)
        chk(ao.data[c], 16'(ai.data[c] + (d[3][3] ? {{8{d[4][7]}}, d[4]} : 16'h0000)));
      for (int i = 0; i < 7; i++) rdx(ADR[i], d[i] & MSK[i]);
    end
    // ----
    // watchdog: disabled, short period, long period
    // ----
    im <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      acc(1'b1, 1'b0, SNC_OFF_PERSIST, 8'(2 + 2 * k));
      pin <= 1'b0;
      n = 0;
      while (to !== 1'b1 && n < 100)
      begin
        @(posedge ref_clk);
        n++;
      end
      pin <= 1'b1;
      chk(k == 0 ? n == 100 : (n > 20 * k && n < 20 * k + 5) || (n > 60 && n < 65), 1);
      repeat (4) @(posedge ref_clk);
    end
    im <= 1'b0;
    // ----
    // programming: refused while disabled or busy, image frozen at start
    // ----
    acc(1'b1, 1'b0, SNC_OFF_NVM_MODE, 8'h00);
    acc(1'b1, 1'b0, SNC_OFF_PERSIST, 8'h0B);
    acc(1'b1, 1'b0, SNC_OFF_X_OFFSET, 8'h5A);
    p0 = progs;
    acc(1'b1, 1'b0, SNC_OFF_CMD, SNC_CMD_NVM_PROG);
    repeat (3) @(posedge ref_clk);
    chk(progs, p0);
    dly <= 8'h09;
    acc(1'b1, 1'b0, SNC_OFF_NVM_MODE, 8'h02);
    acc(1'b1, 1'b0, SNC_OFF_CMD, SNC_CMD_NVM_PROG);
    acc(1'b1, 1'b0, SNC_OFF_X_OFFSET, 8'h11);
    acc(1'b1, 1'b0, SNC_OFF_CMD, SNC_CMD_NVM_PROG);
    n = 0;
    while (busy !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (3) @(posedge ref_clk);
    chk(progs, p0 + 1);
    chk(nv_img, {4'hB, 8'h5A});
    // restore after a reset from the stored image
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    nld <= 1'b1;
    @(posedge ref_clk);
    nld <= 1'b0;
    rdx(SNC_OFF_PERSIST, 8'h0B);
    rdx(SNC_OFF_X_OFFSET, 8'h5A);
    repeat (4) @(posedge ref_clk);
    wrap_up();
  end
endmodule
